/* shared/pdwl_pkg.sv */
/*
 * Constants shared by the disable-register write-lock block: data width,
 * bit positions in the control and configuration words, write targets,
 * reset values and the default unlock keys.
 * Assumes a single 32-bit system bus clock and one device reset.
 */
package pdwl_pkg;

	// ==========================================================
	// widths and field positions
	localparam int DATA_W = 32;
	localparam int LOCK_BIT = 12;      // lock in config_control_reg
	localparam int ONE_WAY_BIT = 28;   // option in device_config_word3
	localparam int SEL_W = 2;

	// ==========================================================
	// write targets on the request port
	localparam logic [SEL_W-1:0] SEL_KEY = 2'h0;
	localparam logic [SEL_W-1:0] SEL_CFG = 2'h1;
	localparam logic [SEL_W-1:0] SEL_DIS = 2'h2;

	// ==========================================================
	// reset values
	localparam logic LOCK_RST = 1'b0;
	localparam logic ONE_WAY_RST = 1'b1;  // safe side until strap is caught
	localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;

	// ==========================================================
	// default unlock keys (values arbitrary)
	localparam logic [DATA_W-1:0] KEY_FIRST = 32'h5A3C_0F96;
	localparam logic [DATA_W-1:0] KEY_SECOND = 32'hC369_A5F0;

endpackage

/* hdl/pdwl_unlock_seq.sv */
/*
 * Unlock sequencer: two consecutive key writes open a one-change window.
 * Assumes all request strobes are one-cycle pulses on clk.
 */
module pdwl_unlock_seq import pdwl_pkg::*; #(
	parameter logic [DATA_W-1:0] KEY1 = KEY_FIRST,
	parameter logic [DATA_W-1:0] KEY2 = KEY_SECOND
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic key_wr,
	input wire logic other_wr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic enable,
	input wire logic consume,
	output logic unlocked
);

	typedef enum logic {PDWL_IDLE, PDWL_GOT1} pdwl_seq_t;

	pdwl_seq_t state;
	pdwl_seq_t next_state;
	logic next_unlocked;

	// ==========================================================
	// key sequence decode
	always_comb begin
		next_state = state;
		next_unlocked = unlocked;
		if (consume) begin
			next_unlocked = 1'b0;
		end
		if (!enable) begin
			// attempts are ignored while the option holds the lock [RL5]
			next_state = PDWL_IDLE;
			next_unlocked = 1'b0;
		end else if (other_wr) begin
			next_state = PDWL_IDLE; // any foreign write aborts [RL7]
		end else if (key_wr) begin
			unique case (state)
				PDWL_IDLE: begin
					if (wr_data == KEY1) begin
						next_state = PDWL_GOT1;
					end
				end
				PDWL_GOT1: begin
					if (wr_data == KEY2) begin
						next_state = PDWL_IDLE;
						next_unlocked = 1'b1; // [RL3] [RL7]
					end else if (wr_data == KEY1) begin
						next_state = PDWL_GOT1; // restart on a fresh first key
					end else begin
						next_state = PDWL_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= PDWL_IDLE;
			unlocked <= 1'b0;
		end else begin
			state <= next_state;
			unlocked <= next_unlocked;
		end
	end

	// ==========================================================
	// checks
	property p_key_pair_opens;
		@(posedge clk) disable iff (!rst_b)
		(enable && key_wr && !other_wr && state == PDWL_GOT1
			&& wr_data == KEY2) |=> unlocked;
	endproperty
	a_key_pair_opens: assert property (p_key_pair_opens) // [RL7]
		else $error("second key after first did not unlock");

	property p_abort;
		@(posedge clk) disable iff (!rst_b)
		(other_wr && !unlocked) |=> (state == PDWL_IDLE && !unlocked);
	endproperty
	a_abort: assert property (p_abort) // [RL7]
		else $error("foreign write did not abort key sequence");

endmodule // pdwl_unlock_seq

/* hdl/pdwl_lock_top.sv */
/*
 * Write protection for the peripheral disable registers: a lock bit in
 * the configuration control register, an unlock key sequence and a
 * one-way option taken from device configuration word 3.
 * Assumes software writes arrive as one-cycle strobes on clk and that
 * device_config_word3 comes from outside the clock domain.
 */
// Function
// [RL1] Locked writes to disable registers complete normally but change nothing.
// [RL2] Lock is config control bit 12; one blocks, zero allows writes.
// [RL3] Lock bit changes only after a completed unlock sequence.
// [RL4] With one-way option set, lock cannot return to zero once set.
// [RL5] One-way mode with lock set ignores every unlock attempt.
// [RL6] In one-way mode only device reset clears the lock.
// [RL7] Unlock is two consecutive key writes; other writes abort it (a write with wr_sel 3 does not abort the sequence).
module pdwl_lock_top import pdwl_pkg::*; #(
	parameter int NUM_REGS = 4,
	parameter int IDX_W = 2,
	parameter logic [DATA_W-1:0] KEY1 = KEY_FIRST,
	parameter logic [DATA_W-1:0] KEY2 = KEY_SECOND
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_valid,
	input wire logic [SEL_W-1:0] wr_sel,
	input wire logic [IDX_W-1:0] wr_index,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [DATA_W-1:0] device_config_word3,
	output logic wr_done,
	output logic [NUM_REGS*DATA_W-1:0] peripheral_disable_regs,
	output logic [DATA_W-1:0] config_control_reg,
	output logic disable_regs_lock,
	output logic unlocked,
	output logic lock_one_way_option
);

	// ==========================================================
	// strap synchroniser and capture
	logic opt_s1;
	logic opt_s2;
	logic opt_s3;
	logic opt_taken;
	logic next_opt_taken;
	logic next_one_way;
	logic [2:0] fill;
	logic [2:0] next_fill;

	// capture once, after the second and third stage agree; the fill
	// marker keeps the equal reset values of the stages from counting
	always_comb begin
		next_fill = {fill[1:0], 1'b1};
		next_opt_taken = opt_taken;
		next_one_way = lock_one_way_option;
		if (!opt_taken && fill[2] && opt_s2 == opt_s3) begin
			next_opt_taken = 1'b1;
			next_one_way = opt_s3;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			opt_s1 <= 1'b0;
			opt_s2 <= 1'b0;
			opt_s3 <= 1'b0;
			fill <= 3'h0;
			opt_taken <= 1'b0;
			lock_one_way_option <= ONE_WAY_RST;
		end else begin
			opt_s1 <= device_config_word3[ONE_WAY_BIT];
			opt_s2 <= opt_s1;
			opt_s3 <= opt_s2;
			fill <= next_fill;
			opt_taken <= next_opt_taken;
			lock_one_way_option <= next_one_way;
		end
	end

	// ==========================================================
	// request decode
	logic key_wr;
	logic cfg_wr;
	logic dis_wr;
	logic seq_enable;
	logic consume;

	assign key_wr = wr_valid && wr_sel == SEL_KEY;
	assign cfg_wr = wr_valid && wr_sel == SEL_CFG;
	assign dis_wr = wr_valid && wr_sel == SEL_DIS;
	// held lock plus option shuts the sequencer out entirely [RL5]
	assign seq_enable = !(lock_one_way_option && disable_regs_lock);
	assign consume = cfg_wr && unlocked;

	pdwl_unlock_seq #(
		.KEY1(KEY1),
		.KEY2(KEY2)
	) u_seq (
		.clk(clk),
		.rst_b(rst_b),
		.key_wr(key_wr),
		.other_wr(cfg_wr || dis_wr),
		.wr_data(wr_data),
		.enable(seq_enable),
		.consume(consume),
		.unlocked(unlocked)
	);

	// ==========================================================
	// config control register and lock bit
	logic [DATA_W-1:0] next_cfg;
	logic next_lock;

	// one unlock grants one config write, so a stray later write can't
	// flip the lock; other bits of the word belong elsewhere, held at zero
	always_comb begin
		next_lock = disable_regs_lock;
		if (consume) begin
			next_lock = wr_data[LOCK_BIT]; // [RL2] [RL3]
			if (lock_one_way_option && disable_regs_lock) begin
				next_lock = 1'b1; // no return to zero [RL4] [RL6]
			end
		end
		next_cfg = REG_RST;
		next_cfg[LOCK_BIT] = next_lock;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			disable_regs_lock <= LOCK_RST; // reset is the only clear in one-way mode [RL6]
			config_control_reg <= REG_RST;
		end else begin
			disable_regs_lock <= next_lock;
			config_control_reg <= next_cfg;
		end
	end

	// ==========================================================
	// peripheral disable registers
	logic [NUM_REGS*DATA_W-1:0] next_regs;

	// writes land only while the lock is clear [RL2]
	always_comb begin
		next_regs = peripheral_disable_regs;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (dis_wr && !disable_regs_lock
					&& wr_index == IDX_W'(i)) begin
				next_regs[i*DATA_W +: DATA_W] = wr_data; // [RL1]
			end
		end
	end

	// every write is acknowledged, taken or not, so software sees no fault
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			peripheral_disable_regs <= {NUM_REGS{REG_RST}};
			wr_done <= 1'b0;
		end else begin
			peripheral_disable_regs <= next_regs;
			wr_done <= wr_valid; // [RL1]
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_locked_write;
		(dis_wr && disable_regs_lock)
			|=> (wr_done && $stable(peripheral_disable_regs));
	endproperty
	a_locked_write: assert property (p_locked_write) // [RL1]
		else $error("locked write changed a disable register");

	property p_open_write;
		(dis_wr && !disable_regs_lock && wr_index == '0)
			|=> peripheral_disable_regs[DATA_W-1:0] == $past(wr_data);
	endproperty
	a_open_write: assert property (p_open_write) // [RL2]
		else $error("unlocked write did not take effect");

	property p_lock_change;
		!$stable(disable_regs_lock) |-> $past(unlocked) && $past(cfg_wr);
	endproperty
	a_lock_change: assert property (p_lock_change) // [RL3]
		else $error("lock changed without unlock");

	property p_one_way_hold;
		(lock_one_way_option && disable_regs_lock) |=> disable_regs_lock;
	endproperty
	a_one_way_hold: assert property (p_one_way_hold) // [RL4]
		else $error("lock cleared in one-way mode");

	property p_option_frozen;
		opt_taken |=> $stable(lock_one_way_option);
	endproperty
	a_option_frozen: assert property (p_option_frozen) // [RL4]
		else $error("captured one-way option changed");

	property p_one_way_ignore;
		(lock_one_way_option && disable_regs_lock)
			|=> !unlocked [*3];
	endproperty
	a_one_way_ignore: assert property (p_one_way_ignore) // [RL5]
		else $error("unlock accepted in one-way mode");

	property p_one_way_frozen;
		(lock_one_way_option && disable_regs_lock && dis_wr)
			|-> ##1 (disable_regs_lock
				&& $stable(peripheral_disable_regs)) [*2];
	endproperty
	a_one_way_frozen: assert property (p_one_way_frozen) // [RL6]
		else $error("disable registers written in one-way lock");

endmodule // pdwl_lock_top

/* tb/pdwl_lock_top_tb.sv */
/*
 * Self-checking bench for the disable-register write lock: open writes,
 * lock set through the key sequence, aborted unlock, one-way option.
 * Assumes pdwl_pkg is compiled first and default top parameters.
 */
module pdwl_lock_top_tb import pdwl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// stimulus and observation signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic wr_valid = 1'b0;
	logic [SEL_W-1:0] wr_sel = SEL_KEY;
	logic [1:0] wr_index = 2'h0;
	logic [DATA_W-1:0] wr_data = 32'h0000_0000;
	logic [DATA_W-1:0] device_config_word3 = 32'h0000_0000;
	logic wr_done;
	logic [4*DATA_W-1:0] peripheral_disable_regs;
	logic [DATA_W-1:0] config_control_reg;
	logic disable_regs_lock;
	logic unlocked;
	logic lock_one_way_option;
	int fail_count = 0;
	int cmp_count = 0;

	// 5 ns period, 200 MHz
	always #2.5 clk = ~clk;

	pdwl_lock_top u_dut (
		.clk(clk),
		.rst_b(rst_b),
		.wr_valid(wr_valid),
		.wr_sel(wr_sel),
		.wr_index(wr_index),
		.wr_data(wr_data),
		.device_config_word3(device_config_word3),
		.wr_done(wr_done),
		.peripheral_disable_regs(peripheral_disable_regs),
		.config_control_reg(config_control_reg),
		.disable_regs_lock(disable_regs_lock),
		.unlocked(unlocked),
		.lock_one_way_option(lock_one_way_option)
	);

	// ==========================================================
	// shared helpers
	task automatic summarize();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// case equality so an unknown never passes
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [31:0] dreg(input int i);
		return peripheral_disable_regs[i*32+:32];
	endfunction

	// one-cycle strobe; done must show in the following cycle
	task automatic wr(input logic [1:0] sel, input logic [1:0] idx,
		input logic [31:0] d);
		@(negedge clk);
		wr_valid = 1'b1;
		wr_sel = sel;
		wr_index = idx;
		wr_data = d;
		@(negedge clk);
		wr_valid = 1'b0;
		chk("wr_done", 32'h0000_0001, {31'h0, wr_done});
	endtask

	task automatic unlock();
		wr(SEL_KEY, 2'h0, KEY_FIRST);
		wr(SEL_KEY, 2'h0, KEY_SECOND);
	endtask

	// option is a strap, so it is held steady across the release
	task automatic do_reset(input logic opt);
		rst_b = 1'b0;
		device_config_word3 = {3'h0, opt, 28'h000_0000};
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		chk("one_way", {31'h0, opt}, {31'h0, lock_one_way_option});
		chk("lock_rst", 32'h0000_0000, {31'h0, disable_regs_lock});
		chk("cfg_rst", 32'h0000_0000, config_control_reg);
		chk("dis3_rst", 32'h0000_0000, dreg(3));
	endtask

	// ==========================================================
	// scenarios
	task automatic t_open_and_lock();
		wr(2'h3, 2'h0, 32'h0000_1000);
		chk("cfg_selnone", 32'h0000_0000, config_control_reg);
		wr(SEL_DIS, 2'h3, 32'hA5A5_0003);
		chk("dis3_open", 32'hA5A5_0003, dreg(3));
		wr(SEL_CFG, 2'h0, 32'h0000_1000);
		chk("cfg_nokey", 32'h0000_0000, config_control_reg);
		unlock();
		chk("unlocked", 32'h0000_0001, {31'h0, unlocked});
		wr(SEL_CFG, 2'h0, 32'h0000_1000);
		chk("cfg_lock", 32'h0000_1000, config_control_reg);
		chk("consumed", 32'h0000_0000, {31'h0, unlocked});
		wr(SEL_DIS, 2'h3, 32'h1234_5678);
		chk("dis3_locked", 32'hA5A5_0003, dreg(3));
	endtask

	task automatic t_abort_then_clear();
		wr(SEL_KEY, 2'h0, KEY_FIRST);
		wr(SEL_DIS, 2'h1, 32'h0000_0011);
		wr(SEL_KEY, 2'h0, KEY_SECOND);
		chk("aborted", 32'h0000_0000, {31'h0, unlocked});
		unlock();
		wr(SEL_CFG, 2'h0, 32'h0000_0000);
		chk("lock_clr", 32'h0000_0000, {31'h0, disable_regs_lock});
		wr(SEL_DIS, 2'h0, 32'h0F0F_0000);
		chk("dis0_open", 32'h0F0F_0000, dreg(0));
	endtask

	// one-way: set once, then nothing but reset reopens the registers
	task automatic t_one_way();
		do_reset(1'b1);
		unlock();
		wr(SEL_CFG, 2'h0, 32'h0000_1000);
		chk("ow_lock", 32'h0000_0001, {31'h0, disable_regs_lock});
		unlock();
		chk("ow_nokey", 32'h0000_0000, {31'h0, unlocked});
		wr(SEL_CFG, 2'h0, 32'h0000_0000);
		chk("ow_held", 32'h0000_0001, {31'h0, disable_regs_lock});
		wr(SEL_DIS, 2'h2, 32'h0000_00FF);
		chk("ow_dis2", 32'h0000_0000, dreg(2));
		do_reset(1'b1);
		wr(SEL_DIS, 2'h2, 32'h0000_00FF);
		chk("rst_dis2", 32'h0000_00FF, dreg(2));
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		do_reset(1'b0);
		t_open_and_lock();
		t_abort_then_clear();
		t_one_way();
		summarize();
	end

	// about 22 writes and 3 resets fit well inside this span
	initial begin
		#20000;
		fail_count++;
		summarize();
	end

endmodule // pdwl_lock_top_tb
